/* hdl/tdt_control.sv */
// top: host port decode, steering, storage latches, two tune channels
`timescale 1ns/1ps
module tdt_control
  import tdt_pkg::*;
(
  // clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  // host parallel bus
  input  wire logic     data_valid,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_in,
  // write-back to host
  output logic [7:0]    wback_data,
  output logic          wback_oe,
  // tune outputs
  output logic [TDT_SUM_BITS-1:0] coarse_tune,
  output logic [TDT_SUM_BITS-1:0] fine_tune,
  output logic          coarse_hold,
  output logic          fine_hold,
  output logic          update_done
);
  logic [2:0]  dv_sync;
  logic        dv_state;
  logic        next_dv_state;
  tdt_bus_t    bus_q;
  tdt_bus_t    next_bus_q;
  logic        wr_edge;
  logic [7:0]  steer;
  logic [7:0]  next_steer;
  logic [7:0]  latch [TDT_NUM_LATCH];
  logic [7:0]  next_latch [TDT_NUM_LATCH];
  logic [2:0]  byte_cnt;
  logic [2:0]  next_byte_cnt;
  logic        next_update_done;
  logic [1:0]  load;
  logic [7:0]  next_wback_data;
  logic        next_wback_oe;
  tdt_codes_t  codes [2];
  tdt_chan_t   chan [2];
  logic        hold_track_select [2];

  // strobe sync: second and third stages must agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dv_sync  <= 3'h0;
      dv_state <= 1'b0;
      bus_q    <= '0;
    end else begin
      dv_sync  <= {dv_sync[1:0], data_valid};
      dv_state <= next_dv_state;
      bus_q    <= next_bus_q;
    end
  end

  always_comb begin
    next_dv_state = dv_state;
    if (dv_sync[2] == dv_sync[1]) begin
      next_dv_state = dv_sync[2];
    end
    next_bus_q = bus_q;
    next_bus_q.strobe = 1'b0;
    // take address and data once, when the strobe first settles high
    if (next_dv_state && !dv_state) begin
      next_bus_q.addr = addr;
      next_bus_q.data = data_in;
    end
    // latch on the trailing edge of data valid
    if (dv_state && !next_dv_state) begin
      next_bus_q.strobe = 1'b1;
    end
  end

  assign wr_edge = bus_q.strobe;

  always_comb begin
    next_steer = steer;
    next_byte_cnt = byte_cnt;
    next_update_done = 1'b0;
    load = 2'b00;
    for (int i = 0; i < TDT_NUM_LATCH; i++) begin
      next_latch[i] = latch[i];
    end
    if (wr_edge && bus_q.addr == TDT_ADDR_STEER) begin
      next_steer = bus_q.data;
      next_byte_cnt = 3'h1;
    end else if (wr_edge && bus_q.addr == TDT_ADDR_DATA) begin
      for (int i = 0; i < TDT_NUM_LATCH; i++) begin
        // active-low enable steers the byte
        if (!steer[TDT_STEER_EN_LSB+i]) begin
          next_latch[i] = bus_q.data;
          load[i/3] = 1'b1;
        end
      end
      if (byte_cnt != 3'h0) begin
        next_byte_cnt = byte_cnt + 3'h1;
        if (byte_cnt == 3'(TDT_BYTES_PER_UPD - 1)) begin
          next_update_done = 1'b1;
          next_byte_cnt = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      steer       <= TDT_STEER_RST;
      byte_cnt    <= 3'h0;
      update_done <= 1'b0;
      for (int i = 0; i < TDT_NUM_LATCH; i++) begin
        latch[i] <= TDT_LATCH_RST;
      end
    end else begin
      steer       <= next_steer;
      byte_cnt    <= next_byte_cnt;
      update_done <= next_update_done;
      for (int i = 0; i < TDT_NUM_LATCH; i++) begin
        latch[i] <= next_latch[i];
      end
    end
  end

  // separate coarse and fine code assembly
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      codes[c].high_code = {latch[3*c+TDT_LAT_HIGH], latch[3*c+TDT_LAT_MID][7:4]};
      codes[c].low_code  = {latch[3*c+TDT_LAT_MID][3:0], latch[3*c+TDT_LAT_LOW]};
    end
  end

  assign hold_track_select[0] = steer[TDT_STEER_HOLD_C];
  assign hold_track_select[1] = steer[TDT_STEER_HOLD_F];

  tdt_channel u_coarse (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .hold_track_select (hold_track_select[0]),
    .codes             (codes[0]),
    .load_pulse        (load[0]),
    .chan              (chan[0])
  );

  tdt_channel u_fine (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .hold_track_select (hold_track_select[1]),
    .codes             (codes[1]),
    .load_pulse        (load[1]),
    .chan              (chan[1])
  );

  // write-back: equal and above flags per channel while addressed
  always_comb begin
    next_wback_oe = dv_state && bus_q.addr == TDT_ADDR_WBACK;
    next_wback_data = {4'h0, chan[1].above, chan[1].equal, chan[0].above, chan[0].equal};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wback_data  <= 8'h00;
      wback_oe    <= 1'b0;
      coarse_tune <= '0;
      fine_tune   <= '0;
      coarse_hold <= 1'b0;
      fine_hold   <= 1'b0;
    end else begin
      wback_data  <= next_wback_data;
      wback_oe    <= next_wback_oe;
      coarse_tune <= chan[0].tune;
      fine_tune   <= chan[1].tune;
      coarse_hold <= chan[0].hold;
      fine_hold   <= chan[1].hold;
    end
  end
endmodule : tdt_control

/* hdl/tdt_pkg.sv */
// package: constants and carriers for the tandem tune converter control
package tdt_pkg;

  // host port addresses
  localparam logic [7:0] TDT_ADDR_STEER = 8'h70;
  localparam logic [7:0] TDT_ADDR_DATA  = 8'h71;
  localparam logic [7:0] TDT_ADDR_WBACK = 8'h80;

  // steering byte fields (latch enables are active low)
  localparam int TDT_STEER_HOLD_C  = 0;
  localparam int TDT_STEER_HOLD_F  = 7;
  localparam int TDT_STEER_EN_LSB  = 1;
  localparam int TDT_NUM_LATCH     = 6;
  localparam int TDT_BYTES_PER_UPD = 7;

  // latch order: coarse low, coarse mid, coarse high, then fine
  localparam int TDT_LAT_LOW  = 0;
  localparam int TDT_LAT_MID  = 1;
  localparam int TDT_LAT_HIGH = 2;

  // converter geometry
  localparam int TDT_HI_BITS   = 12;
  localparam int TDT_LO_BITS   = 12;
  localparam int TDT_OVERLAP   = 3;
  localparam int TDT_SUM_BITS  = TDT_HI_BITS + TDT_LO_BITS - TDT_OVERLAP + 1;

  // reset values
  localparam logic [7:0] TDT_STEER_RST = 8'h00;
  localparam logic [7:0] TDT_LATCH_RST = 8'h00;

  // settle time between a code load and a valid comparison
  localparam int TDT_SETTLE_NS  = 200;
  localparam int TDT_CLK_NS     = 50;
  localparam int TDT_SETTLE_CYC = (TDT_SETTLE_NS + TDT_CLK_NS - 1) / TDT_CLK_NS;

  typedef struct packed {
    logic       strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } tdt_bus_t;

  typedef struct packed {
    logic [TDT_HI_BITS-1:0] high_code;
    logic [TDT_LO_BITS-1:0] low_code;
  } tdt_codes_t;

  typedef struct packed {
    logic                    hold;
    logic [TDT_SUM_BITS-1:0] tune;
    logic [TDT_SUM_BITS-1:0] held;
    logic                    above;
    logic                    equal;
  } tdt_chan_t;

endpackage : tdt_pkg

/* hdl/tdt_channel.sv */
// one tune channel: dac summing, track/hold and comparison
`timescale 1ns/1ps
module tdt_channel
  import tdt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       hold_track_select,
  input  wire tdt_codes_t codes,
  input  wire logic       load_pulse,
  // result
  output tdt_chan_t       chan
);
  logic [TDT_SUM_BITS-1:0] sum;
  logic [TDT_SUM_BITS-1:0] next_tune;
  logic [TDT_SUM_BITS-1:0] next_held;
  logic [3:0]              settle;
  logic [3:0]              next_settle;
  tdt_chan_t               next_chan;

  always_comb begin
    // low msb carries the weight of the third high lsb
    sum = TDT_SUM_BITS'({codes.high_code, {(TDT_LO_BITS-TDT_OVERLAP){1'b0}}})
        + TDT_SUM_BITS'(codes.low_code);
    next_tune = chan.tune;
    next_held = chan.held;
    next_settle = settle;
    if (!hold_track_select) begin
      next_tune = sum;
      next_held = sum;
    end else begin
      next_held = chan.held;  // frozen reference
      next_tune = sum;
    end
    if (load_pulse) begin
      next_settle = 4'(TDT_SETTLE_CYC);
    end else if (settle != 4'h0) begin
      next_settle = settle - 4'h1;
    end
    next_chan = chan;
    next_chan.hold = hold_track_select;
    next_chan.tune = next_tune;
    next_chan.held = next_held;
    if (settle == 4'h1) begin
      // compare only once settled, ahead of the next query
      next_chan.above = next_tune > next_held;
      next_chan.equal = next_tune == next_held;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chan   <= '0;
      settle <= 4'h0;
    end else begin
      chan   <= next_chan;
      settle <= next_settle;
    end
  end
endmodule : tdt_channel

/* test/tdt_control_asserts.sv */
// checker: port timing of the tune converter control
`timescale 1ns/1ps
module tdt_control_asserts
  import tdt_pkg::*;
(
  // watched ports
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    data_valid,
  input wire logic [7:0]              wback_data,
  input wire logic                    wback_oe,
  input wire logic [TDT_SUM_BITS-1:0] coarse_tune,
  input wire logic [TDT_SUM_BITS-1:0] fine_tune,
  input wire logic                    coarse_hold,
  input wire logic                    fine_hold,
  input wire logic                    update_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_wback_top_zero: assert property (wback_data[7:4] == 4'h0)
    else $error("write-back top nibble set");
  a_wback_one_way: assert property (wback_data[0] |-> !wback_data[1])
    else $error("equal and above both set");
  a_oe_after_strobe: assert property ($rose(wback_oe) |-> $past(data_valid, 3))
    else $error("write-back enabled without strobe");
  a_done_one_cycle: assert property (update_done |=> !update_done)
    else $error("update done longer than one cycle");
  a_done_after_fall: assert property ($rose(update_done) |-> !data_valid)
    else $error("update done inside strobe");
  a_mode_on_fall: assert property ($changed(coarse_hold) |-> !data_valid)
    else $error("coarse mode moved inside strobe");
  a_fine_mode_fall: assert property ($changed(fine_hold) |-> !data_valid)
    else $error("fine mode moved inside strobe");
  a_tune_after_load: assert property ($changed(coarse_tune) |-> !data_valid)
    else $error("coarse tune moved inside strobe");
  a_fine_after_load: assert property ($changed(fine_tune) |-> !data_valid)
    else $error("fine tune moved inside strobe");
endmodule : tdt_control_asserts
bind tdt_control tdt_control_asserts u_chk (.sys_clk, .rst_n, .data_valid, .wback_data,
  .wback_oe, .coarse_tune, .fine_tune, .coarse_hold, .fine_hold, .update_done);

/* test/tdt_host.sv */
// host model: byte writes and reads on the parallel bus
`timescale 1ns/1ps
module tdt_host (
  // bus
  input wire logic        sys_clk,
  input wire logic [7:0]  wback_data,
  input wire logic        wback_oe,
  output logic            data_valid,
  output logic [7:0]      addr,
  output logic [7:0]      data_in
);
  logic [7:0] rd;
  initial begin
    data_valid = 1'b0;
    addr = 8'h00;
    data_in = 8'h00;
    rd = 8'h00;
  end
  // strobe held 8 cycles, released lines inverted, 10 idle cycles
  task put(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #2;
    addr = a;
    data_in = d;
    data_valid = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
    if (wback_oe) rd = wback_data;
    data_valid = 1'b0;
    addr = ~a;
    data_in = ~d;
    repeat (10) @(posedge sys_clk);
  endtask : put
endmodule : tdt_host

/* test/tdt_control_tb.sv */
// bench: tune converter control scenarios
`timescale 1ns/1ps
module tdt_control_tb;
  import tdt_pkg::*;
  logic                    sys_clk;
  logic                    rst_n;
  logic                    data_valid;
  logic [7:0]              addr;
  logic [7:0]              data_in;
  logic [7:0]              wback_data;
  logic                    wback_oe;
  logic [TDT_SUM_BITS-1:0] coarse_tune;
  logic [TDT_SUM_BITS-1:0] fine_tune;
  logic                    coarse_hold;
  logic                    fine_hold;
  logic                    update_done;
  int                      bad_count;
  int                      checks;
  int                      done_cnt;
  int                      cyc;
  tdt_control dut (.sys_clk, .rst_n, .data_valid, .addr, .data_in, .wback_data, .wback_oe,
    .coarse_tune, .fine_tune, .coarse_hold, .fine_hold, .update_done);
  tdt_host host (.sys_clk, .wback_data, .wback_oe, .data_valid, .addr, .data_in);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (update_done === 1'b1) done_cnt <= done_cnt + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function logic [31:0] sum_of(input logic [7:0] lo, input logic [7:0] mid,
                               input logic [7:0] hi);
    return ({20'h0, hi, mid[7:4]} << (TDT_LO_BITS - TDT_OVERLAP)) + {20'h0, mid[3:0], lo};
  endfunction : sum_of
  task t_full();
    host.put(TDT_ADDR_STEER, 8'h00);
    repeat (5) host.put(TDT_ADDR_DATA, 8'hff);
    chk(done_cnt, 0);
    host.put(TDT_ADDR_DATA, 8'hff);
    chk(done_cnt, 1);
    chk(coarse_tune, sum_of(8'hff, 8'hff, 8'hff));
    chk(fine_tune, sum_of(8'hff, 8'hff, 8'hff));
    chk({coarse_hold, fine_hold}, 0);
  endtask : t_full
  task t_steer();
    host.put(TDT_ADDR_STEER, 8'h76);
    host.put(TDT_ADDR_DATA, 8'h80);
    chk(coarse_tune, sum_of(8'hff, 8'hff, 8'h80));
    chk(fine_tune, sum_of(8'hff, 8'hff, 8'hff));
    host.put(8'h55, 8'h00);
    host.put(TDT_ADDR_STEER, 8'h7e);
    host.put(TDT_ADDR_DATA, 8'h00);
    chk(coarse_tune, sum_of(8'hff, 8'hff, 8'h80));
  endtask : t_steer
  task t_search();
    host.put(TDT_ADDR_STEER, 8'h00);
    host.put(TDT_ADDR_DATA, 8'h00);
    host.put(TDT_ADDR_STEER, 8'h81);
    chk({coarse_hold, fine_hold}, 2'b11);
    host.put(TDT_ADDR_WBACK, 8'h00);
    chk(host.rd, 8'h05);
    host.put(TDT_ADDR_STEER, 8'hfd);
    host.put(TDT_ADDR_DATA, 8'h01);
    chk(coarse_tune, 1);
    host.put(TDT_ADDR_WBACK, 8'h00);
    chk(host.rd, 8'h06);
    host.put(TDT_ADDR_DATA, 8'h00);
    host.put(TDT_ADDR_WBACK, 8'h00);
    chk(host.rd, 8'h05);
    host.put(TDT_ADDR_STEER, 8'h00);
    chk({coarse_hold, fine_hold}, 0);
  endtask : t_search
  task close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    @(posedge sys_clk) #2;
    chk({coarse_tune, wback_oe, update_done}, 0);
    t_full();
    t_steer();
    t_search();
    close_out();
  end
endmodule : tdt_control_tb
